// ==== hw/dtg_top.v ====
// How it works
// - four row and four column tones
// - code table maps digit to tone pair
// - transmit write latches code, one-of-eight select
// - period is 32 segments, divider restarts
// - divider pulses step sine table, two chains
// - free running clock, tone starts at once
// - burst and pause each 51 ms
// - ready bit set after burst and pause
// - call progress burst doubles to 102 ms
// - no digit registered in call progress
// - call progress square wave on pin, gated by irq enable
// - power-up gives normal and burst mode
// - single tone mode picks row or column
// - select line steers data and control access
// - control a: redirect, irq, call progress, tone
// - control b: column, single, test, burst
// - redirect sends next control write to b
// - tone enable bit gates the output
// - interrupt low on digit or tx ready
// - reset clears both control registers
`timescale 1ns/10ps
`include "dtg_map.vh"
module dtg_top #(
	parameter DIV_W     = 16,
	parameter BURST_CYC = `DTG_BURST_CYC
) (
	// clock, reset, enable
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       clk_en,
	// host port
	input  wire       register_select,
	input  wire       rd_strobe,
	input  wire       wr_strobe,
	input  wire [3:0] data_in,
	output reg  [3:0] data_out,
	output reg        data_oe,
	// receiver side: validated digit and in-band square wave
	input  wire       rx_digit_valid,
	input  wire [3:0] rx_digit_code,
	input  wire       rx_steer,
	input  wire       cp_square,
	// tone samples and interrupt pin
	output reg  [7:0] row_sample,
	output reg  [7:0] col_sample,
	output reg        tone_active,
	output reg        interrupt_or_tone_out_n
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_BURST = 2'd1;
	localparam ST_PAUSE = 2'd2;

	reg  [3:0]       control_a_r;
	reg  [3:0]       control_b_r;
	reg              redirect_r;
	reg  [3:0]       tx_code_r;
	reg  [3:0]       rx_data_r;
	reg              rx_valid_r;
	reg              tx_ready_r;
	reg  [1:0]       state_r;
	reg  [31:0]      burst_cnt_r;
	reg              pend_r;
	reg              rd_d_r;
	reg              wr_d_r;
	wire             rd_edge;
	wire             wr_edge;
	wire             tone_en;
	wire             call_progress_mode;
	wire             burst_en;
	wire [31:0]      interval;
	wire [7:0]       row_onehot;
	wire [7:0]       col_onehot;
	wire [DIV_W-1:0] row_term;
	wire [DIV_W-1:0] col_term;
	wire             row_run;
	wire             col_run;
	wire             gen_on;
	wire             row_pulse;
	wire             col_pulse;
	wire [7:0]       row_s;
	wire [7:0]       col_s;

	// code to tone pair
	// row index 0..3 (697,770,852,941) from the digit code
	function [1:0] code_row;
		input [3:0] c;
		begin
			case (c)
				4'h1, 4'h2, 4'h3, 4'hD: code_row = 2'd0;
				4'h4, 4'h5, 4'h6, 4'hE: code_row = 2'd1;
				4'h7, 4'h8, 4'h9, 4'hF: code_row = 2'd2;
				default:                code_row = 2'd3;
			endcase
		end
	endfunction

	// column index 0..3 (1209,1336,1477,1633) from the digit code
	function [1:0] code_col;
		input [3:0] c;
		begin
			case (c)
				4'h1, 4'h4, 4'h7, 4'hB: code_col = 2'd0;
				4'h2, 4'h5, 4'h8, 4'hA: code_col = 2'd1;
				4'h3, 4'h6, 4'h9, 4'hC: code_col = 2'd2;
				default:                code_col = 2'd3;
			endcase
		end
	endfunction

	// segment length in clocks: clk / (freq * 32), minus one for terminal
	function [DIV_W-1:0] seg_term;
		input [7:0] sel;
		begin
			case (sel)
				8'h01:   seg_term = 16'h2BC7;
				8'h02:   seg_term = 16'h27A1;
				8'h04:   seg_term = 16'h23D0;
				8'h08:   seg_term = 16'h206C;
				8'h10:   seg_term = 16'h193D;
				8'h20:   seg_term = 16'h16D7;
				8'h40:   seg_term = 16'h14A8;
				default: seg_term = 16'h12AF;
			endcase
		end
	endfunction

	assign tone_en            = control_a_r[`DTG_CRA_TONE_EN];
	assign call_progress_mode = control_a_r[`DTG_CRA_CALL_PROG];
	assign burst_en           = ~control_b_r[`DTG_CRB_BURST_OFF];
	assign interval = call_progress_mode ? (BURST_CYC * 2) : BURST_CYC;
	assign rd_edge  = rd_strobe & ~rd_d_r;
	assign wr_edge  = wr_strobe & ~wr_d_r;

	assign row_onehot = 8'h01 << code_row(tx_code_r);
	assign col_onehot = 8'h10 << code_col(tx_code_r);
	assign row_term = seg_term(row_onehot);
	assign col_term = seg_term(col_onehot);

	// tone enable gates generation, burst phases too
	assign gen_on = tone_en & (burst_en ? (state_r == ST_BURST) : 1'b1);
	// single tone keeps row or column only
	assign row_run = gen_on & ~(control_b_r[`DTG_CRB_SINGLE] & control_b_r[`DTG_CRB_COL_SEL]);
	assign col_run = gen_on & ~(control_b_r[`DTG_CRB_SINGLE] & ~control_b_r[`DTG_CRB_COL_SEL]);

	dtg_divider #(.WIDTH(DIV_W)) u_row_div (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.run       (row_run),
		.terminal  (row_term),
		.seg_pulse (row_pulse)
	);
	dtg_sine u_row_sine (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.run     (row_run),
		.advance (row_pulse),
		.sample  (row_s)
	);
	dtg_divider #(.WIDTH(DIV_W)) u_col_div (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.run       (col_run),
		.terminal  (col_term),
		.seg_pulse (col_pulse)
	);
	dtg_sine u_col_sine (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.run     (col_run),
		.advance (col_pulse),
		.sample  (col_s)
	);

	// host port: strobes sampled for edges, writes act once per strobe
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rd_d_r      <= 1'b0;
			wr_d_r      <= 1'b0;
			// zero gives normal and burst mode
			control_a_r <= `DTG_CTRL_RESET;
			control_b_r <= `DTG_CTRL_RESET;
			redirect_r  <= 1'b0;
			tx_code_r   <= `DTG_CODE_RESET;
		end
		else if (clk_en)
		begin
			rd_d_r <= rd_strobe;
			wr_d_r <= wr_strobe;
			if (wr_edge && !register_select)
				// select low write is transmit data
				tx_code_r <= data_in;
			else if (wr_edge && register_select)
			begin
				// redirected write lands in b once
				if (redirect_r)
				begin
					control_b_r <= data_in;
					redirect_r  <= 1'b0;
				end
				else
				begin
					control_a_r <= data_in;
					redirect_r  <= data_in[`DTG_CRA_REDIRECT];
				end
			end
		end
	end

	// burst sequencer: new code starts a burst, then equal pause
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			state_r     <= ST_IDLE;
			burst_cnt_r <= 32'd0;
			pend_r      <= 1'b0;
			tx_ready_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_edge && !register_select)
				pend_r <= 1'b1;
			case (state_r)
				ST_IDLE:
				begin
					burst_cnt_r <= 32'd0;
					if (burst_en && tone_en && (pend_r || (wr_edge && !register_select)))
					begin
						state_r <= ST_BURST;
						pend_r  <= 1'b0;
					end
				end
				ST_BURST:
				begin
					if (burst_cnt_r >= interval - 32'd1)
					begin
						burst_cnt_r <= 32'd0;
						state_r     <= ST_PAUSE;
					end
					else
						burst_cnt_r <= burst_cnt_r + 32'd1;
				end
				default:
				begin
					if (burst_cnt_r >= interval - 32'd1)
					begin
						burst_cnt_r <= 32'd0;
						state_r     <= ST_IDLE;
					end
					else
						burst_cnt_r <= burst_cnt_r + 32'd1;
				end
			endcase
			// ready set after pause; set beats read clear
			if (state_r == ST_PAUSE && burst_cnt_r >= interval - 32'd1)
				tx_ready_r <= 1'b1;
			else if (rd_edge && register_select)
				tx_ready_r <= 1'b0;
		end
	end

	// receive data latch and valid flag
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rx_data_r  <= 4'h0;
			rx_valid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rx_digit_valid && !call_progress_mode)
			begin
				rx_data_r  <= rx_digit_code;
				rx_valid_r <= 1'b1;
			end
			else if (rd_edge && register_select)
				rx_valid_r <= 1'b0;
		end
	end

	// registered outputs
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			data_out                <= 4'h0;
			data_oe                 <= 1'b0;
			row_sample              <= 8'h80;
			col_sample              <= 8'h80;
			tone_active             <= 1'b0;
			interrupt_or_tone_out_n <= 1'b1;
		end
		else if (clk_en)
		begin
			data_oe <= rd_strobe;
			if (register_select)
				data_out <= {rx_steer, rx_valid_r, tx_ready_r,
					~interrupt_or_tone_out_n};
			else
				data_out <= rx_data_r;
			row_sample  <= row_s;
			col_sample  <= col_s;
			tone_active <= row_run | col_run;
			// in-band square wave, gated by irq enable
			if (call_progress_mode)
				interrupt_or_tone_out_n <= ~(cp_square & control_a_r[`DTG_CRA_IRQ_EN]);
			else
				// irq on digit or ready in burst
				interrupt_or_tone_out_n <= ~(control_a_r[`DTG_CRA_IRQ_EN]
					& (rx_valid_r | (tx_ready_r & burst_en)));
		end
	end
endmodule // dtg_top

// ==== hw/dtg_map.vh ====
`ifndef DTG_MAP_VH
`define DTG_MAP_VH
// control register a fields
`define DTG_CRA_TONE_EN      0
`define DTG_CRA_CALL_PROG    1
`define DTG_CRA_IRQ_EN       2
`define DTG_CRA_REDIRECT     3
// control register b fields
`define DTG_CRB_BURST_OFF    0
`define DTG_CRB_TEST         1
`define DTG_CRB_SINGLE       2
`define DTG_CRB_COL_SEL      3
// status register fields
`define DTG_ST_IRQ           0
`define DTG_ST_TX_READY      1
`define DTG_ST_RX_VALID      2
`define DTG_ST_STEER         3
// reset values
`define DTG_CTRL_RESET       4'h0
`define DTG_CODE_RESET       4'h0
// timing: segments per tone period and burst interval
`define DTG_SEGMENTS         32
`define DTG_CLK_KHZ          250000
`define DTG_BURST_MS         51
`define DTG_BURST_CYC        (`DTG_BURST_MS * `DTG_CLK_KHZ)
`endif

// ==== hw/dtg_divider.v ====
`timescale 1ns/10ps
// programmable segment divider: counts to terminal value, pulses, restarts
module dtg_divider #(
	parameter WIDTH = 16
) (
	// clock and reset
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             clk_en,
	// control
	input  wire             run,
	input  wire [WIDTH-1:0] terminal,
	// segment advance pulse
	output reg              seg_pulse
);
	reg [WIDTH-1:0] cnt_r;

	// count, pulse at terminal, restart from zero
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			cnt_r     <= {WIDTH{1'b0}};
			seg_pulse <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!run)
			begin
				cnt_r     <= {WIDTH{1'b0}};
				seg_pulse <= 1'b0;
			end
			else if (cnt_r >= terminal)
			begin
				cnt_r     <= {WIDTH{1'b0}};
				seg_pulse <= 1'b1;
			end
			else
			begin
				cnt_r     <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
				seg_pulse <= 1'b0;
			end
		end
	end
endmodule // dtg_divider

// ==== hw/dtg_sine.v ====
`timescale 1ns/10ps
// 32-entry sine table addressed by a segment counter
module dtg_sine (
	// clock and reset
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       clk_en,
	// control
	input  wire       run,
	input  wire       advance,
	// sample out, offset binary, mid scale when idle
	output reg  [7:0] sample
);
	reg [4:0] phase_r;

	// offset-binary sine, one entry per segment
	function [7:0] sine_lut;
		input [4:0] idx;
		begin
			case (idx)
				5'h00: sine_lut = 8'h80;
				5'h01: sine_lut = 8'h98;
				5'h02: sine_lut = 8'hB0;
				5'h03: sine_lut = 8'hC6;
				5'h04: sine_lut = 8'hD9;
				5'h05: sine_lut = 8'hE8;
				5'h06: sine_lut = 8'hF5;
				5'h07: sine_lut = 8'hFC;
				5'h08: sine_lut = 8'hFF;
				5'h09: sine_lut = 8'hFC;
				5'h0A: sine_lut = 8'hF5;
				5'h0B: sine_lut = 8'hE8;
				5'h0C: sine_lut = 8'hD9;
				5'h0D: sine_lut = 8'hC6;
				5'h0E: sine_lut = 8'hB0;
				5'h0F: sine_lut = 8'h98;
				5'h10: sine_lut = 8'h80;
				5'h11: sine_lut = 8'h67;
				5'h12: sine_lut = 8'h4F;
				5'h13: sine_lut = 8'h39;
				5'h14: sine_lut = 8'h26;
				5'h15: sine_lut = 8'h17;
				5'h16: sine_lut = 8'h0A;
				5'h17: sine_lut = 8'h03;
				5'h18: sine_lut = 8'h01;
				5'h19: sine_lut = 8'h03;
				5'h1A: sine_lut = 8'h0A;
				5'h1B: sine_lut = 8'h17;
				5'h1C: sine_lut = 8'h26;
				5'h1D: sine_lut = 8'h39;
				5'h1E: sine_lut = 8'h4F;
				default: sine_lut = 8'h67;
			endcase
		end
	endfunction

	// phase walks the table; idle parks at mid scale
	always @(posedge mclk)
	begin
		if (!reset_n)
		begin
			phase_r <= 5'h00;
			sample  <= 8'h80;
		end
		else if (clk_en)
		begin
			if (!run)
			begin
				phase_r <= 5'h00;
				sample  <= 8'h80;
			end
			else
			begin
				if (advance)
					phase_r <= phase_r + 5'h01;
				sample <= sine_lut(phase_r);
			end
		end
	end
endmodule // dtg_sine

// ==== dv/dtg_monitor.sv ====
`timescale 1ns/10ps
module dtg_monitor #(
	parameter BURST_CYC = 200
) (
	// clock and reset
	input wire       mclk,
	input wire       reset_n,
	// host port
	input wire       register_select,
	input wire       rd_strobe,
	input wire       wr_strobe,
	input wire [3:0] data_in,
	input wire [3:0] data_out,
	input wire       data_oe,
	// receiver side
	input wire       rx_digit_valid,
	input wire [3:0] rx_digit_code,
	input wire       cp_square,
	// tone and pin
	input wire [7:0] row_sample,
	input wire [7:0] col_sample,
	input wire       tone_active,
	input wire       interrupt_or_tone_out_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	reg [3:0] ca_r, cb_r, rx_r;
	reg       redir_r, wr_q;
	integer   on_cnt;
	// shadow of control writes, rx code and burst length
	always @(posedge mclk)
	begin
		wr_q <= wr_strobe;
		on_cnt <= tone_active ? on_cnt + 1 : 0;
		if (!reset_n)
		begin
			ca_r <= 4'h0;
			cb_r <= 4'h0;
			rx_r <= 4'h0;
			redir_r <= 1'b0;
		end
		else
		begin
			if (rx_digit_valid && !ca_r[1])
				rx_r <= rx_digit_code;
			if (wr_strobe && !wr_q && register_select && redir_r)
				cb_r <= data_in;
			if (wr_strobe && !wr_q && register_select && !redir_r)
				ca_r <= data_in;
			if (wr_strobe && !wr_q && register_select)
				redir_r <= !redir_r && data_in[3];
		end
	end
	a_idle_mid: assert property (!tone_active [*3] |-> row_sample == 8'h80 && col_sample == 8'h80)
		else $error("sample off mid scale while idle");
	a_tone_off: assert property (!ca_r[0] && !$past(ca_r[0]) |=> !tone_active)
		else $error("tone runs while disabled");
	a_oe_follow: assert property ($rose(rd_strobe) |=> data_oe)
		else $error("read enable missing");
	a_rx_read: assert property (rd_strobe && $past(rd_strobe) && !register_select && !$past(register_select) |-> data_out == rx_r)
		else $error("receive data wrong");
	a_irq_off: assert property (!ca_r[2] && !$past(ca_r[2]) |=> interrupt_or_tone_out_n)
		else $error("pin low while interrupts off");
	a_cp_pin: assert property (ca_r[2:1] == 2'b11 && $past(ca_r[2:1]) == 2'b11 |=> interrupt_or_tone_out_n == !$past(cp_square))
		else $error("square wave not on pin");
	a_burst_len: assert property ($fell(tone_active) && ca_r[1:0] == 2'b01 && !cb_r[0] |-> on_cnt >= BURST_CYC - 2 && on_cnt <= BURST_CYC + 2)
		else $error("burst length wrong");
	a_cp_burst: assert property ($fell(tone_active) && ca_r[1:0] == 2'b11 && !cb_r[0] |-> on_cnt >= 2 * BURST_CYC - 4 && on_cnt <= 2 * BURST_CYC + 4)
		else $error("long burst length wrong");
	a_single: assert property (cb_r[2] && $past(cb_r[2], 4) && cb_r[3] == $past(cb_r[3], 4) |-> (cb_r[3] ? row_sample : col_sample) == 8'h80)
		else $error("second tone in single mode");
	a_status_clr: assert property ($rose(rd_strobe) && register_select && ca_r[2:1] == 2'b10 && !rx_digit_valid |-> ##2 interrupt_or_tone_out_n)
		else $error("status read left pin low");
	c_burst: cover property ($fell(tone_active) && !cb_r[0]);
	c_cp_low: cover property (ca_r[2:1] == 2'b11 && !interrupt_or_tone_out_n);
	c_single: cover property (cb_r[2] && tone_active);
endmodule // dtg_monitor

bind dtg_top dtg_monitor #(.BURST_CYC(BURST_CYC)) u_mon (.mclk, .reset_n, .register_select,
	.rd_strobe, .wr_strobe, .data_in, .data_out, .data_oe, .rx_digit_valid, .rx_digit_code,
	.cp_square, .row_sample, .col_sample, .tone_active, .interrupt_or_tone_out_n);

// ==== dv/dtg_host.sv ====
`timescale 1ns/10ps
module dtg_host (
	// clock
	input  wire       mclk,
	// read return
	input  wire [3:0] data_out,
	input  wire       data_oe,
	// strobes and data
	output reg        register_select,
	output reg        rd_strobe,
	output reg        wr_strobe,
	output reg  [3:0] data_in
);
	// idle bus
	initial
	begin
		register_select = 1'b0;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		data_in = 4'h0;
	end
	task wr(input logic rs, input logic [3:0] d);
	begin
		@(negedge mclk);
		register_select = rs;
		data_in = d;
		wr_strobe = 1'b1;
		@(negedge mclk);
		wr_strobe = 1'b0;
		data_in = ~d; // released bus shows no stale value
		@(negedge mclk);
	end
	endtask
	// read returns X unless the port drives
	task rd(input logic rs, output logic [3:0] d);
	begin
		@(negedge mclk);
		register_select = rs;
		rd_strobe = 1'b1;
		// take the word one clock after the strobe edge, before the status clear shows
		@(negedge mclk);
		d = data_oe ? data_out : 4'hX;
		@(negedge mclk);
		rd_strobe = 1'b0;
		@(negedge mclk);
	end
	endtask
endmodule // dtg_host

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	localparam BC = 200;
	logic       mclk = 1'b0;
	logic       reset_n = 1'b0;
	logic       rx_digit_valid = 1'b0;
	logic [3:0] rx_digit_code = 4'h0;
	logic       cp_square = 1'b0;
	wire        register_select, rd_strobe, wr_strobe, data_oe, tone_active, irq_n;
	wire  [3:0] data_in, data_out;
	wire  [7:0] row_sample, col_sample;
	integer     error_cnt = 0, n_tests = 0, seed = 2118, n, k, code;
	logic [3:0] st, rxq[$];
	int         fr[4] = '{697, 770, 852, 941};
	int         fc[4] = '{1209, 1336, 1477, 1633};
	// design and host
	dtg_top #(.BURST_CYC(BC)) u_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
		.register_select(register_select), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.rx_digit_valid(rx_digit_valid), .rx_digit_code(rx_digit_code), .rx_steer(1'b0),
		.cp_square(cp_square), .row_sample(row_sample), .col_sample(col_sample),
		.tone_active(tone_active), .interrupt_or_tone_out_n(irq_n));
	dtg_host u_host (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
		.register_select(register_select), .rd_strobe(rd_strobe),
		.wr_strobe(wr_strobe), .data_in(data_in));
	always #2 mclk = ~mclk;
	// code to row and column index
	function automatic int row_of(int c);
		return (c >= 1 && c <= 9) ? (c - 1) / 3 : (c >= 13) ? c - 13 : 3;
	endfunction
	function automatic int col_of(int c);
		return (c >= 1 && c <= 9) ? (c - 1) % 3 : (c == 10) ? 1 : (c == 11) ? 0 : (c == 12) ? 2 : 3;
	endfunction
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %0h seen %0h", nm, exp, seen);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// wait for a burst, return start delay and length
	task burst_len(output int w, output int b);
	begin
		w = 0;
		b = 0;
		while (tone_active !== 1'b1 && w < 4 * BC)
		begin
			@(negedge mclk);
			w++;
		end
		while (tone_active === 1'b1 && b < 4 * BC)
		begin
			@(negedge mclk);
			b++;
		end
	end
	endtask
	// one segment length, measured between two sample steps
	task automatic seg_len(input bit col, output int s);
		logic [7:0] v;
	begin
		s = 0;
		v = col ? col_sample : row_sample;
		while ((col ? col_sample : row_sample) === v && s < 30000)
		begin
			@(negedge mclk);
			s++;
		end
		v = col ? col_sample : row_sample;
		s = 0;
		while ((col ? col_sample : row_sample) === v && s < 30000)
		begin
			@(negedge mclk);
			s++;
		end
	end
	endtask
	task rx_pulse(input logic [3:0] c);
	begin
		@(negedge mclk);
		rx_digit_code = c;
		rx_digit_valid = 1'b1;
		@(negedge mclk);
		rx_digit_valid = 1'b0;
		rx_digit_code = ~c;
		repeat (2) @(negedge mclk);
	end
	endtask
	// watchdog at 90k cycles, well above the roughly 41k the tests need
	initial
	begin
		#360000;
		error_cnt++;
		finish_test;
	end
	// main sequence
	initial
	begin : main
		int s1, s2;
		repeat (2) @(negedge mclk);
		reset_n = 1'b1;
		check("reset", {tone_active, irq_n, row_sample, col_sample}, 18'h18080);
		code = $random(seed) & 15;
		u_host.wr(0, code[3:0]);
		repeat (20) @(negedge mclk);
		check("held", tone_active, 0);
		u_host.wr(1, 4'h5);
		burst_len(k, n);
		check("start", k <= 4, 1);
		check("burst", n >= BC - 2 && n <= BC + 2, 1);
		u_host.rd(1, st);
		check("early", st[1], 0);
		repeat (BC) @(negedge mclk);
		check("tx irq", irq_n, 0);
		u_host.rd(1, st);
		check("ready", st[1], 1);
		check("irq clr", irq_n, 1);
		u_host.rd(1, st);
		check("ready clr", st[1], 0);
		code = $random(seed) & 15;
		rx_pulse(code[3:0]);
		rxq.push_back(code[3:0]);
		check("rx irq", irq_n, 0);
		u_host.rd(0, st);
		check("rx data", st, rxq[$]);
		u_host.wr(1, 4'h6);
		cp_square = 1'b1;
		repeat (3) @(negedge mclk);
		check("cp low", irq_n, 0);
		cp_square = 1'b0;
		repeat (3) @(negedge mclk);
		check("cp high", irq_n, 1);
		rx_pulse(~code[3:0]);
		u_host.wr(0, code[3:0]);
		u_host.wr(1, 4'h7);
		burst_len(k, n);
		check("cp burst", n >= 2 * BC - 4 && n <= 2 * BC + 4, 1);
		repeat (2 * BC + 4) @(negedge mclk);
		u_host.rd(0, st);
		check("cp rx", st, rxq[$]);
		u_host.wr(1, 4'h9);
		u_host.wr(1, 4'h5);
		repeat (3 * BC) @(negedge mclk);
		check("row only", {tone_active, col_sample}, 9'h180);
		u_host.wr(1, 4'h9);
		u_host.wr(1, 4'hD);
		repeat (5) @(negedge mclk);
		check("col only", {tone_active, row_sample}, 9'h180);
		// a write that lands in a turns tone off and irq on (rx still valid)
		u_host.wr(1, 4'h4);
		repeat (5) @(negedge mclk);
		check("back to a", {tone_active, irq_n}, 2'b00);
		u_host.wr(1, 4'h8);
		u_host.wr(1, 4'h1);
		for (int i = 0; i < 2; i++)
		begin
			code = i ? 0 : 1;
			u_host.wr(0, code[3:0]);
			u_host.wr(1, 4'h1);
			fork
				seg_len(0, s1);
				seg_len(1, s2);
			join
			n = s1 - 250000000 / (32 * fr[row_of(code)]);
			k = s2 - 250000000 / (32 * fc[col_of(code)]);
			check("row seg", n >= -2 && n <= 2, 1);
			check("col seg", k >= -2 && k <= 2, 1);
			u_host.wr(1, 4'h0);
		end
		finish_test;
	end
endmodule // tb_top
